// *** logic/hk_pkg.sv ***
// package with register map, fields and timing for the housekeeping scheduler
// Behaviour
// - rtc_run_enable keeps measurements running in low power
// - ext voltage period bits 5-4: none/8/2/1 min
// - battery period bits 3-2: none/16/4/1 min
// - temperature period bits 1-0: none/8/2/1 min
// - temperature delta bits 5-3: 000 never, 1, 2 LSB
// - temperature codes 3 to 6 LSB, 111 always
// - ext voltage delta bits 2-0, same coding
// - start bit set by software, cleared on accept
package hk_pkg;
  localparam logic [7:0] ADDR_TEMPERATURE_RESULT = 8'hd7;
  localparam logic [7:0] ADDR_MEASUREMENT_START  = 8'hd8;
  localparam logic [7:0] ADDR_BATTERY_RESULT     = 8'hdf;
  localparam logic [7:0] ADDR_EXT_VOLTAGE_RESULT = 8'hef;
  localparam logic [7:0] ADDR_DELTA_THRESHOLD    = 8'hf3;
  localparam logic [7:0] ADDR_STROBE_PERIOD      = 8'hf9;
  localparam logic [7:0] ADDR_BATTERY_THRESHOLD  = 8'hfa;
  localparam logic [7:0] ADDR_RTC_CONFIG         = 8'ha1;
  // field positions
  localparam int EXT_PERIOD_LSB  = 4;
  localparam int BAT_PERIOD_LSB  = 2;
  localparam int TEMP_PERIOD_LSB = 0;
  localparam int TEMP_DELTA_LSB  = 3;
  localparam int EXT_DELTA_LSB   = 0;
  localparam int START_EXT_BIT   = 2;
  localparam int START_TEMP_BIT  = 1;
  localparam int START_BAT_BIT   = 0;
  localparam int RTC_RUN_BIT     = 0;
  localparam logic [7:0] START_MASK   = 8'h07;
  localparam logic [7:0] PERIOD_MASK  = 8'h3f;
  localparam logic [7:0] DELTA_MASK   = 8'h3f;
  localparam logic [7:0] RESET_VALUE  = 8'h00;
  localparam logic [2:0] DELTA_NEVER  = 3'h0;
  localparam logic [2:0] DELTA_ALWAYS = 3'h7;
  // quantity indices
  localparam int Q_BAT  = 0;
  localparam int Q_TEMP = 1;
  localparam int Q_EXT  = 2;
  // timing
  localparam longint CLK_HZ        = 250_000_000;
  localparam longint SEC_PER_MIN   = 60;
  localparam longint MINUTE_CYCLES = CLK_HZ * SEC_PER_MIN;
  // interval in minutes for codes 01, 10, 11
  localparam int EXT_MIN_C1  = 8;
  localparam int EXT_MIN_C2  = 2;
  localparam int BAT_MIN_C1  = 16;
  localparam int BAT_MIN_C2  = 4;
  localparam int TEMP_MIN_C1 = 8;
  localparam int TEMP_MIN_C2 = 2;
  localparam int MIN_C3      = 1;
endpackage

// *** logic/hk_req_if.sv ***
// interface carrying one quantity's tick, period settings, run and due flag between modules
`timescale 1ns/100ps
interface hk_req_if;
  logic       tick;
  logic [1:0] period;
  logic [4:0] minutes_c1;
  logic [4:0] minutes_c2;
  logic       run;
  logic       due;
  modport ctrl (output tick, period, minutes_c1, minutes_c2, run,
                input  due);
  modport sched (input tick, period, minutes_c1, minutes_c2, run,
                 output due);
endinterface

// *** logic/hk_interval.sv ***
// interval counter of one quantity in whole minutes
`timescale 1ns/100ps
module hk_interval (
  // clocking
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  // control
  hk_req_if.sched   req
);
  logic [4:0] min_cnt_reg;
  logic [4:0] limit;

  always_comb begin
    case (req.period)
      2'h1:    limit = req.minutes_c1;
      2'h2:    limit = req.minutes_c2;
      2'h3:    limit = 5'(hk_pkg::MIN_C3);
      default: limit = 5'h0;
    endcase
  end

  // restart from zero whenever the period is off so a new choice counts fully
  always_ff @(posedge ref_clk) begin
    if (srst || req.period == 2'h0) begin
      min_cnt_reg <= 5'h0;
    end else if (clk_en && req.run && req.tick) begin
      if (min_cnt_reg + 5'h1 >= limit) begin
        min_cnt_reg <= 5'h0;
      end else begin
        min_cnt_reg <= min_cnt_reg + 5'h1;
      end
    end
  end

  assign req.due = (req.period != 2'h0) && req.run && req.tick &&
                   (min_cnt_reg + 5'h1 >= limit);
endmodule

// *** logic/hk_scheduler.sv ***
// housekeeping measurement scheduler with delta interrupt filter
`timescale 1ns/100ps
module hk_scheduler #(
  parameter longint MINUTE_CYCLES = hk_pkg::MINUTE_CYCLES
) (
  // clocking
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // power state
  input  wire logic       low_power_mode_one,
  input  wire logic       low_power_mode_two,
  // shared adc
  output logic      [2:0] adc_req,
  input  wire logic [2:0] adc_ack,
  input  wire logic [2:0] adc_done,
  input  wire logic [7:0] adc_result,
  // core interrupt events
  output logic            temp_change_irq,
  output logic            ext_change_irq
);
  logic [7:0]  strobe_period_config_reg;
  logic [7:0]  delta_threshold_config_reg;
  logic [7:0]  measurement_start_reg;
  logic [7:0]  battery_threshold_config_reg;
  logic [7:0]  rtc_config_register_reg;
  logic [7:0]  temperature_result_reg;
  logic [7:0]  battery_result_reg;
  logic [7:0]  ext_voltage_result_reg;
  logic [7:0]  temp_last_irq_reg;
  logic [7:0]  ext_last_irq_reg;
  logic [2:0]  pending_reg;
  logic [35:0] cyc_cnt_reg;
  logic        minute_tick;
  logic        run;
  logic [2:0]  due;
  logic [2:0]  sw_start;
  logic        temp_hit;
  logic        ext_hit;

  localparam logic [35:0] MIN_LAST = 36'(MINUTE_CYCLES - 1);

  // low power only halts the schedule unless the rtc keeps running
  assign run = !(low_power_mode_one || low_power_mode_two) ||
               rtc_config_register_reg[hk_pkg::RTC_RUN_BIT];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_cnt_reg <= 36'h0_0000_0000;
    end else if (clk_en && run) begin
      cyc_cnt_reg <= minute_tick ? 36'h0_0000_0000 : cyc_cnt_reg + 36'h1;
    end
  end
  assign minute_tick = (cyc_cnt_reg == MIN_LAST);

  hk_req_if bat_if ();
  hk_req_if tmp_if ();
  hk_req_if ext_if ();

  assign ext_if.period = strobe_period_config_reg[
    hk_pkg::EXT_PERIOD_LSB +: 2];
  assign ext_if.minutes_c1 = 5'(hk_pkg::EXT_MIN_C1);
  assign ext_if.minutes_c2 = 5'(hk_pkg::EXT_MIN_C2);
  assign bat_if.period = strobe_period_config_reg[
    hk_pkg::BAT_PERIOD_LSB +: 2];
  assign bat_if.minutes_c1 = 5'(hk_pkg::BAT_MIN_C1);
  assign bat_if.minutes_c2 = 5'(hk_pkg::BAT_MIN_C2);
  assign tmp_if.period = strobe_period_config_reg[
    hk_pkg::TEMP_PERIOD_LSB +: 2];
  assign tmp_if.minutes_c1 = 5'(hk_pkg::TEMP_MIN_C1);
  assign tmp_if.minutes_c2 = 5'(hk_pkg::TEMP_MIN_C2);
  assign bat_if.tick = minute_tick;
  assign tmp_if.tick = minute_tick;
  assign ext_if.tick = minute_tick;
  assign bat_if.run = run;
  assign tmp_if.run = run;
  assign ext_if.run = run;

  hk_interval u_bat (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .req     (bat_if.sched)
  );
  hk_interval u_tmp (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .req     (tmp_if.sched)
  );
  hk_interval u_ext (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .req     (ext_if.sched)
  );
  assign due = {ext_if.due, tmp_if.due, bat_if.due};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      strobe_period_config_reg     <= hk_pkg::RESET_VALUE;
      delta_threshold_config_reg   <= hk_pkg::RESET_VALUE;
      battery_threshold_config_reg <= hk_pkg::RESET_VALUE;
      rtc_config_register_reg      <= hk_pkg::RESET_VALUE;
    end else if (clk_en && sfr_wr) begin
      case (sfr_addr)
        hk_pkg::ADDR_STROBE_PERIOD:
          strobe_period_config_reg <= sfr_wdata & hk_pkg::PERIOD_MASK;
        hk_pkg::ADDR_DELTA_THRESHOLD:
          delta_threshold_config_reg <= sfr_wdata & hk_pkg::DELTA_MASK;
        hk_pkg::ADDR_BATTERY_THRESHOLD:
          battery_threshold_config_reg <= sfr_wdata;
        hk_pkg::ADDR_RTC_CONFIG:
          rtc_config_register_reg <= sfr_wdata;
        default: ;
      endcase
    end
  end

  // start bits: software sets, adc acceptance clears; a new write wins
  assign sw_start = (sfr_wr && sfr_addr == hk_pkg::ADDR_MEASUREMENT_START)
                    ? sfr_wdata[2:0] : 3'h0;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      measurement_start_reg <= hk_pkg::RESET_VALUE;
    end else if (clk_en) begin
      measurement_start_reg[2:0] <= (measurement_start_reg[2:0] &
                                     ~adc_ack) | sw_start;
    end
  end

  // background requests wait here until the adc accepts them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pending_reg <= 3'h0;
    end else if (clk_en) begin
      pending_reg <= (pending_reg & ~adc_ack) | due;
    end
  end
  assign adc_req = pending_reg | measurement_start_reg[2:0];

  function automatic logic delta_hit(input logic [2:0] code,
                                     input logic [7:0] now,
                                     input logic [7:0] last);
    logic [7:0] diff;
    diff = (now > last) ? now - last : last - now;
    if (code == hk_pkg::DELTA_NEVER) begin
      delta_hit = 1'b0;
    end else if (code == hk_pkg::DELTA_ALWAYS) begin
      delta_hit = 1'b1;
    end else begin
      delta_hit = diff >= {5'h0, code};
    end
  endfunction

  assign temp_hit = adc_done[hk_pkg::Q_TEMP] && delta_hit(
    delta_threshold_config_reg[hk_pkg::TEMP_DELTA_LSB +: 3],
    adc_result, temp_last_irq_reg);
  assign ext_hit = adc_done[hk_pkg::Q_EXT] && delta_hit(
    delta_threshold_config_reg[hk_pkg::EXT_DELTA_LSB +: 3],
    adc_result, ext_last_irq_reg);

  // results may also be written by software, as the registers are R/W
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      temperature_result_reg <= hk_pkg::RESET_VALUE;
      battery_result_reg     <= hk_pkg::RESET_VALUE;
      ext_voltage_result_reg <= hk_pkg::RESET_VALUE;
      temp_last_irq_reg      <= hk_pkg::RESET_VALUE;
      ext_last_irq_reg       <= hk_pkg::RESET_VALUE;
      temp_change_irq        <= 1'b0;
      ext_change_irq         <= 1'b0;
    end else if (clk_en) begin
      temp_change_irq <= temp_hit;
      ext_change_irq  <= ext_hit;
      if (adc_done[hk_pkg::Q_TEMP]) begin
        temperature_result_reg <= adc_result;
      end else if (sfr_wr && sfr_addr == hk_pkg::ADDR_TEMPERATURE_RESULT) begin
        temperature_result_reg <= sfr_wdata;
      end
      if (adc_done[hk_pkg::Q_BAT]) begin
        battery_result_reg <= adc_result;
      end else if (sfr_wr && sfr_addr == hk_pkg::ADDR_BATTERY_RESULT) begin
        battery_result_reg <= sfr_wdata;
      end
      if (adc_done[hk_pkg::Q_EXT]) begin
        ext_voltage_result_reg <= adc_result;
      end else if (sfr_wr && sfr_addr == hk_pkg::ADDR_EXT_VOLTAGE_RESULT) begin
        ext_voltage_result_reg <= sfr_wdata;
      end
      if (temp_hit) begin
        temp_last_irq_reg <= adc_result;
      end
      if (ext_hit) begin
        ext_last_irq_reg <= adc_result;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en) begin
      case (sfr_addr)
        hk_pkg::ADDR_TEMPERATURE_RESULT: sfr_rdata <= temperature_result_reg;
        hk_pkg::ADDR_MEASUREMENT_START:  sfr_rdata <= measurement_start_reg;
        hk_pkg::ADDR_BATTERY_RESULT:     sfr_rdata <= battery_result_reg;
        hk_pkg::ADDR_EXT_VOLTAGE_RESULT: sfr_rdata <= ext_voltage_result_reg;
        hk_pkg::ADDR_DELTA_THRESHOLD:
          sfr_rdata <= delta_threshold_config_reg;
        hk_pkg::ADDR_STROBE_PERIOD:     sfr_rdata <= strobe_period_config_reg;
        hk_pkg::ADDR_BATTERY_THRESHOLD:
          sfr_rdata <= battery_threshold_config_reg;
        hk_pkg::ADDR_RTC_CONFIG:        sfr_rdata <= rtc_config_register_reg;
        default:                        sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// *** tb/hk_scheduler_monitor.sv ***
// port checker for the housekeeping scheduler
`timescale 1ns/100ps
module hk_scheduler_monitor #(
  parameter longint MINUTE_CYCLES = 10
) (
  // clocking and register port
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  // adc and events
  input wire logic [2:0] adc_req,
  input wire logic [2:0] adc_ack,
  input wire logic [2:0] adc_done,
  input wire logic       temp_change_irq,
  input wire logic       ext_change_irq
);
  logic [7:0] delta_reg;
  logic [2:0] start_bits;
  logic       done_t;
  logic       done_e;
  assign start_bits = sfr_wdata[2:0];
  assign done_t = adc_done[1] & clk_en;
  assign done_e = adc_done[2] & clk_en;
  // shadow copy, so delta codes are known without peeking inside
  always_ff @(posedge ref_clk) begin
    if (srst)
      delta_reg <= 8'h00;
    else if (clk_en && sfr_wr && sfr_addr == hk_pkg::ADDR_DELTA_THRESHOLD)
      delta_reg <= sfr_wdata;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_req_held_ack:
    assert property (clk_en |=>
      ($past(adc_req) & ~$past(adc_ack) & ~adc_req) == 3'h0)
    else $error("request dropped before ack");
  a_start_sets_req:
    assert property (clk_en && sfr_wr && sfr_addr == 8'hd8 |=>
      (adc_req & $past(start_bits)) == $past(start_bits))
    else $error("start bit gave no request");
  a_temp_irq_cause:
    assert property ($rose(temp_change_irq) |-> $past(done_t))
    else $error("temperature event without result");
  a_ext_irq_cause:
    assert property ($rose(ext_change_irq) |-> $past(done_e))
    else $error("voltage event without result");
  a_temp_never:
    assert property (done_t && delta_reg[5:3] == 3'h0 |=> !temp_change_irq)
    else $error("temperature event with delta off");
  a_temp_always:
    assert property (done_t && delta_reg[5:3] == 3'h7 |=> temp_change_irq)
    else $error("temperature event missing");
  a_ext_never:
    assert property (done_e && delta_reg[2:0] == 3'h0 |=> !ext_change_irq)
    else $error("voltage event with delta off");
  a_ext_always:
    assert property (done_e && delta_reg[2:0] == 3'h7 |=> ext_change_irq)
    else $error("voltage event missing");
endmodule

// *** tb/hk_adc_model.sv ***
// behavioural shared adc serving one request at a time
`timescale 1ns/100ps
module hk_adc_model (
  // clock and latency
  input  wire logic        ref_clk,
  input  wire logic [3:0]  lat,
  // scheduler side
  input  wire logic [2:0]  adc_req,
  input  wire logic [23:0] res,
  output logic      [2:0]  adc_ack,
  output logic      [2:0]  adc_done,
  output logic      [7:0]  adc_result
);
  int q;
  initial begin
    adc_ack = 3'h0;
    adc_done = 3'h0;
    adc_result = 8'h00;
  end
  always begin
    @(negedge ref_clk);
    if (adc_req != 3'h0) begin
      q = adc_req[0] ? 0 : (adc_req[1] ? 1 : 2);
      repeat (lat) @(negedge ref_clk);
      adc_ack[q] = 1'b1;
      @(negedge ref_clk);
      adc_ack = 3'h0;
      adc_done[q] = 1'b1;
      adc_result = res[q*8 +: 8];
      @(negedge ref_clk);
      adc_done = 3'h0;
      // stale data must never pass for a fresh result
      adc_result = ~adc_result;
    end
  end
endmodule

// *** tb/hk_scheduler_tb.sv ***
// self-checking bench for the housekeeping scheduler
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
  fails++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module hk_scheduler_tb;
  localparam longint MIN_CYC = 20;
  logic        ref_clk = 0;
  logic        srst = 1;
  logic        clk_en = 1;
  logic [7:0]  sfr_addr = 0;
  logic        sfr_wr = 0;
  logic [7:0]  sfr_wdata = 0;
  logic [7:0]  sfr_rdata;
  logic        low_power_mode_one = 0;
  logic        low_power_mode_two = 0;
  logic [2:0]  adc_req, adc_ack, adc_done;
  logic [7:0]  adc_result;
  logic        temp_change_irq, ext_change_irq;
  logic [3:0]  lat = 1;
  logic [23:0] res = 0;
  logic [7:0]  last [3] = '{0, 0, 0};
  logic [7:0]  ra [3] = '{8'hdf, 8'hd7, 8'hef};
  int          acks [3] = '{0, 0, 0};
  int          irqs [3] = '{0, 0, 0};
  int          fails = 0;
  int          checks_done = 0;
  hk_scheduler #(.MINUTE_CYCLES(MIN_CYC)) uut (.ref_clk, .srst, .clk_en,
    .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .low_power_mode_one,
    .low_power_mode_two, .adc_req, .adc_ack, .adc_done, .adc_result,
    .temp_change_irq, .ext_change_irq);
  hk_adc_model adc (.ref_clk, .lat, .adc_req, .res, .adc_ack, .adc_done,
    .adc_result);
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++)
      if (adc_ack[i]) acks[i]++;
    if (temp_change_irq) irqs[1]++;
    if (ext_change_irq) irqs[2]++;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    sfr_addr = a;
    @(negedge ref_clk);
    `CHK("sfr_rdata", e, sfr_rdata)
  endtask
  task automatic t_regs();
    rdchk(8'hf3, 8'h00);
    wr(8'hf9, 8'hc0);
    rdchk(8'hf9, 8'h00);
    wr(8'hf3, 8'hff);
    rdchk(8'hf3, 8'h3f);
    wr(8'hf3, 8'h00);
    rdchk(8'h00, 8'h00);
  endtask
  // clk_en low must freeze registers, start bits and read data alike
  task automatic t_freeze();
    wr(8'hf3, 8'h12);
    rdchk(8'hf3, 8'h12);
    clk_en = 1'b0;
    wr(8'hf3, 8'h09);
    wr(8'hd8, 8'h02);
    `CHK("adc_req", 3'h0, adc_req)
    rdchk(8'hd7, 8'h12);
    clk_en = 1'b1;
    rdchk(8'hf3, 8'h12);
    rdchk(8'hd8, 8'h00);
    wr(8'hf3, 8'h00);
  endtask
  task automatic t_manual();
    lat = 4'd3;
    for (int i = 0; i < 3; i++) begin
      res[i*8 +: 8] = 8'h30 + 8'(i);
      wr(8'hd8, 8'h01 << i);
      `CHK("adc_req", 1'b1, adc_req[i])
      rdchk(8'hd8, 8'h01 << i);
      repeat (8) @(negedge ref_clk);
      rdchk(8'hd8, 8'h00);
      rdchk(ra[i], res[i*8 +: 8]);
    end
    lat = 4'd0;
  endtask
  task automatic meas(input int q, input logic [7:0] v, input logic e);
    int base;
    base = irqs[q];
    res[q*8 +: 8] = v;
    wr(8'hd8, 8'h01 << q);
    repeat (6) @(negedge ref_clk);
    // exactly one pulse per interrupting result
    `CHK("irq", int'(e), irqs[q] - base)
    if (e) last[q] = v;
  endtask
  task automatic t_delta();
    for (int q = 1; q < 3; q++)
      for (int c = 0; c < 8; c++) begin
        wr(8'hf3, (q == 1) ? 8'(c << 3) : 8'(c));
        meas(q, last[q] + ((c == 0) ? 8'd5 : 8'(c - 1)), c == 7);
        meas(q, last[q] + 8'(c), c != 0);
      end
    wr(8'hf3, 8'h00);
  endtask
  task automatic t_period();
    int mins [3][4] = '{'{1, 16, 4, 1}, '{1, 8, 2, 1}, '{1, 8, 2, 1}};
    int n;
    int d;
    int base [3];
    for (int c = 0; c < 4; c++) begin
      wr(8'hf9, 8'(c * 21));
      // let requests left over from the last code drain first
      repeat (10) @(negedge ref_clk);
      base = acks;
      repeat (32 * MIN_CYC) @(negedge ref_clk);
      for (int i = 0; i < 3; i++) begin
        n = (c == 0) ? 0 : 32 / mins[i][c];
        d = acks[i] - base[i];
        `CHK("count", 1'b1, d <= n + 1 && d + 1 >= n)
      end
    end
    wr(8'hf9, 8'h00);
  endtask
  task automatic t_low_power();
    int base;
    int d;
    for (int m = 0; m < 4; m++) begin
      wr(8'ha1, 8'(m / 2));
      low_power_mode_one = (m % 2 == 0);
      low_power_mode_two = (m % 2 == 1);
      wr(8'hf9, 8'h03);
      base = acks[1];
      repeat (8 * MIN_CYC) @(negedge ref_clk);
      d = acks[1] - base;
      `CHK("lp", 1'b1, (m > 1) ? d >= 7 : d <= 1)
      wr(8'hf9, 8'h00);
      low_power_mode_one = 1'b0;
      low_power_mode_two = 1'b0;
      repeat (20) @(negedge ref_clk);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    t_regs();
    t_freeze();
    t_manual();
    t_delta();
    t_period();
    t_low_power();
    summarize();
  end
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule
bind hk_scheduler hk_scheduler_monitor #(.MINUTE_CYCLES(MINUTE_CYCLES)) mon (
  .ref_clk, .srst, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata, .adc_req,
  .adc_ack, .adc_done, .temp_change_irq, .ext_change_irq);
